// file: sync_irq_combiner.sv
// Operation
// R1: Combined line is NOR of controller irq, bus error while mastering, sync detected.
// R2: Engine sets line transition flag on falling edge of the combined line.
// R3: Engine raises its interrupt request when flag sets with channel irq enabled.
// R4: Controller has thirteen maskable events across two mask registers.
// R5: Controller drives its interrupt high on an enabled event, pulling line low.
// R6: Reading controller event status releases its interrupt output.
// R7: Software clears controller polarity bit so its interrupt is active high.
// R8: Handshake monitoring arms on the rising edge of the final-byte flag.
// R9: Without carry mode, final byte is terminal strobe together with channel 0 grant.
// R10: With carry mode and carry sent, final byte is next channel 1 grant.
// R11: After the final byte, controller transfer requests are masked.
// R12: Direction 0: rising edge of data-valid sets the detector, line falls.
// R13: Direction 1: high level of data-valid sets the detector, line falls.
// R14: Any config write clears the detector and returns the line high; here a detector set in the same cycle wins over the write.
// R15: Engine ends the cycle and flags completion and fault on bus error.
// R16: Bus error also pulls the combined line low, carry mode or not.
// R17: One channel irq enable covers both transition and completion flags.
// R18: Completion flag sets at end, after last block when chained.
// R19: Without carry mode software enables irq on channel 1 only.
// R20: With carry mode channel 1 runs chained with final count two.
// R21: Software aborts channel 1 before the next carry-mode transfer.
// R22: Software completion sequence: status b, a, masks, config, aborts, flags.
// R23: Incoming grant is held off at least 25 ns before use.
// R24: Reset clears detector and arming so the combined line idles high.
`timescale 1ns/1ps
module sync_irq_combiner
(
   input  wire logic                             clk_in,            // 10 MHz clock
   input  wire logic                             rst_in,            // Sync reset, high
   input  wire logic [sync_irq_pkg::APB_AW-1:0]  paddr_in,          // APB address
   input  wire logic                             psel_in,           // APB select
   input  wire logic                             penable_in,        // APB enable
   input  wire logic                             pwrite_in,         // APB direction
   input  wire logic [31:0]                      pwdata_in,         // APB write data
   output logic      [31:0]                      prdata_out,        // APB read data
   output logic                                  pready_out,        // APB ready
   output logic                                  pslverr_out,       // APB error
   input  wire logic                             dav_n_in,          // GPIB data valid, low
   input  wire logic                             tl_irq_in,         // Controller irq, high
   input  wire logic                             bus_exc_code1_n_in,// Bus error code, low
   input  wire logic                             dma_own_n_in,      // Engine owns bus, low
   input  wire logic                             done_n_in,         // Terminal byte, low
   input  wire logic                             chan0_grant_n_in,  // Channel 0 ack, low
   input  wire logic                             chan1_grant_n_in,  // Channel 1 ack, low
   input  wire logic                             carry_sent_in,     // Carry byte sent
   input  wire logic                             tl_xfer_req_in,    // Controller DMA request
   input  wire logic                             grant_in_seen_in,  // Raw bus grant in
   output logic                                  periph_control_line_n_out, // Combined line
   output logic                                  xfer_request_line_out,     // Gated request
   output logic                                  grant_seen_dly_out         // Held-off grant
);
   import sync_irq_pkg::*;

   typedef struct packed
   {
      logic [1:0]  cfg;
      logic        final_prev;
      logic        armed;
      logic        sync_det;
      logic        dav_prev;
      logic        req_mask;
      logic        pcl_n;
      logic        grant_dly;
      logic [31:0] rdata;
   } state_t;

   state_t     st_ff;
   state_t     nxt_st;
   logic [PIN_W-1:0] pin_s;
   logic       dav_hi;
   logic       berr_mst;
   logic       final_byte_flag;
   logic       final_rise;
   logic       cfg_wr;
   logic       apb_setup;
   logic       addr_ok;
   logic       sync_set;

   pin_sync2 #(.W(PIN_W), .INIT(PIN_IDLE)) pin_sync2_i
   (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   ({grant_in_seen_in, chan1_grant_n_in, chan0_grant_n_in, done_n_in,
                dma_own_n_in, bus_exc_code1_n_in, tl_irq_in, dav_n_in}),
      .q_out  (pin_s)
   );

   assign dav_hi    = pin_s[PIN_DAV_N];
   assign berr_mst  = !pin_s[PIN_BERR_N] && !pin_s[PIN_OWN_N];
   assign apb_setup = psel_in && !penable_in;
   assign addr_ok   = (paddr_in == CFG_OFFSET) || (paddr_in == STATUS_OFFSET);
   assign cfg_wr    = psel_in && penable_in && pwrite_in && (paddr_in == CFG_OFFSET);

   always_comb
   begin
      // Final-byte qualification differs with carry mode
      if (st_ff.cfg[CFG_CARRY_BIT])
         final_byte_flag = carry_sent_in && !pin_s[PIN_GRANT1_N];                 // R10
      else
         final_byte_flag = !pin_s[PIN_DONE_N] && !pin_s[PIN_GRANT0_N];            // R9
      final_rise = final_byte_flag && !st_ff.final_prev;                          // R8
      // Set wins over a same-cycle config write so a late handshake is not lost
      if (st_ff.cfg[CFG_DIR_BIT])
         sync_set = st_ff.armed && dav_hi;                                        // R13
      else
         sync_set = st_ff.armed && dav_hi && !st_ff.dav_prev;                     // R12
   end

   always_comb
   begin
      nxt_st            = st_ff;
      nxt_st.final_prev = final_byte_flag;
      nxt_st.dav_prev   = dav_hi;
      nxt_st.grant_dly  = pin_s[PIN_GRANT_SEEN];                                  // R23
      if (cfg_wr)
      begin
         nxt_st.cfg      = pwdata_in[1:0];
         nxt_st.armed    = 1'b0;                                                  // R14
         nxt_st.sync_det = 1'b0;                                                  // R14
         nxt_st.req_mask = 1'b0;
      end
      if (final_rise)
      begin
         nxt_st.armed    = 1'b1;                                                  // R8
         nxt_st.req_mask = 1'b1;                                                  // R11
      end
      if (sync_set)
      begin
         nxt_st.sync_det = 1'b1;
         nxt_st.armed    = 1'b0;
      end
      // Registered NOR keeps the line glitch-free toward the engine
      nxt_st.pcl_n = !(pin_s[PIN_TL_IRQ] || berr_mst || nxt_st.sync_det);         // R1 R16
      if (apb_setup)
      begin
         nxt_st.rdata = 32'h0000_0000;
         if (paddr_in == CFG_OFFSET)
            nxt_st.rdata[1:0] = st_ff.cfg;
         else if (paddr_in == STATUS_OFFSET)
         begin
            nxt_st.rdata[ST_FINAL_BIT] = final_byte_flag;
            nxt_st.rdata[ST_ARMED_BIT] = st_ff.armed;
            nxt_st.rdata[ST_SYNC_BIT]  = st_ff.sync_det;
            nxt_st.rdata[ST_PCL_BIT]   = st_ff.pcl_n;
            nxt_st.rdata[ST_MASK_BIT]  = st_ff.req_mask;
            nxt_st.rdata[ST_DAV_BIT]   = dav_hi;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_ff            <= '0;                                                  // R24
         st_ff.cfg        <= CFG_RESET;
         st_ff.pcl_n      <= 1'b1;                                                // R24
         st_ff.dav_prev   <= 1'b1;
         st_ff.rdata      <= RDATA_RESET;
      end
      else
         st_ff <= nxt_st;
   end

   assign prdata_out                = st_ff.rdata;
   assign pready_out                = 1'b1;
   assign pslverr_out               = psel_in && penable_in && !addr_ok;
   assign periph_control_line_n_out = st_ff.pcl_n;
   assign xfer_request_line_out     = tl_xfer_req_in && !st_ff.req_mask;          // R11
   assign grant_seen_dly_out        = st_ff.grant_dly;

   sequence final_edge_s;
      final_rise && !cfg_wr;
   endsequence

   sequence cfg_clear_s;
      cfg_wr && !sync_set;
   endsequence

   line_nor_a: assert property (@(posedge clk_in) disable iff (rst_in)              // R1
      !$past(rst_in) |-> periph_control_line_n_out ==
         !($past(pin_s[PIN_TL_IRQ]) || $past(berr_mst) || st_ff.sync_det))
      else $error("Combined line is not the NOR of its sources");
   arm_on_rise_a: assert property (@(posedge clk_in) disable iff (rst_in)           // R8
      final_edge_s |=> st_ff.armed || st_ff.sync_det)
      else $error("Final byte edge did not arm the detector");
   final_plain_a: assert property (@(posedge clk_in) disable iff (rst_in)           // R9
      !st_ff.cfg[CFG_CARRY_BIT] && !pin_s[PIN_DONE_N] && !pin_s[PIN_GRANT0_N]
      |-> final_byte_flag)
      else $error("Final byte missed without carry mode");
   final_carry_a: assert property (@(posedge clk_in) disable iff (rst_in)           // R10
      st_ff.cfg[CFG_CARRY_BIT] && (final_byte_flag != (carry_sent_in &&
         !pin_s[PIN_GRANT1_N])) |-> 1'b0)
      else $error("Final byte wrong in carry mode");
   req_mask_a: assert property (@(posedge clk_in) disable iff (rst_in)              // R11
      final_edge_s |=> !xfer_request_line_out)
      else $error("Transfer request not masked after final byte");
   dir0_edge_a: assert property (@(posedge clk_in) disable iff (rst_in)             // R12
      st_ff.armed && !st_ff.cfg[CFG_DIR_BIT] && $rose(dav_hi)
      |=> st_ff.sync_det ##1 !periph_control_line_n_out)
      else $error("Data-valid edge did not pull the line low");
   dir1_level_a: assert property (@(posedge clk_in) disable iff (rst_in)            // R13
      st_ff.armed && st_ff.cfg[CFG_DIR_BIT] && dav_hi
      |=> st_ff.sync_det ##1 !periph_control_line_n_out)
      else $error("Data-valid level did not pull the line low");
   cfg_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)             // R14
      cfg_clear_s ##1 (!pin_s[PIN_TL_IRQ] && !berr_mst)
      |=> periph_control_line_n_out && !st_ff.sync_det)
      else $error("Config write did not release the line");
   bus_err_a: assert property (@(posedge clk_in) disable iff (rst_in)               // R16
      berr_mst |=> !periph_control_line_n_out)
      else $error("Bus error did not pull the line low");
   grant_dly_a: assert property (@(posedge clk_in) disable iff (rst_in)             // R23
      $rose(pin_s[PIN_GRANT_SEEN]) |-> !grant_seen_dly_out ##1 grant_seen_dly_out)
      else $error("Grant not held off by one cycle");
   reset_idle_a: assert property (@(posedge clk_in)                                 // R24
      rst_in |=> periph_control_line_n_out && !st_ff.armed && !st_ff.sync_det)
      else $error("Reset did not idle the line high");
endmodule

// file: sync_irq_pkg.sv
package sync_irq_pkg;
   localparam int          APB_AW          = 4;
   localparam logic [3:0]  CFG_OFFSET      = 4'h0;
   localparam logic [3:0]  STATUS_OFFSET   = 4'h4;
   localparam int          CFG_DIR_BIT     = 0;
   localparam int          CFG_CARRY_BIT   = 1;
   localparam logic [1:0]  CFG_RESET       = 2'h0;
   localparam int          ST_FINAL_BIT    = 0;
   localparam int          ST_ARMED_BIT    = 1;
   localparam int          ST_SYNC_BIT     = 2;
   localparam int          ST_PCL_BIT      = 3;
   localparam int          ST_MASK_BIT     = 4;
   localparam int          ST_DAV_BIT      = 5;
   // Pin vector passed through the two-stage synchroniser
   localparam int          PIN_W           = 8;
   localparam int          PIN_DAV_N       = 0;
   localparam int          PIN_TL_IRQ      = 1;
   localparam int          PIN_BERR_N      = 2;
   localparam int          PIN_OWN_N       = 3;
   localparam int          PIN_DONE_N      = 4;
   localparam int          PIN_GRANT0_N    = 5;
   localparam int          PIN_GRANT1_N    = 6;
   localparam int          PIN_GRANT_SEEN  = 7;
   localparam logic [7:0]  PIN_RESET       = 8'h0;
   localparam logic [7:0]  PIN_IDLE        = 8'h7D;
   // Grant hold-off
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          GRANT_DLY_NS    = 25;
   localparam int          GRANT_DLY_CYC   = (GRANT_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;
endpackage

// file: pin_sync2.sv
`timescale 1ns/1ps
module pin_sync2
   import sync_irq_pkg::*;
#(
   parameter int           W        = PIN_W,
   parameter logic [W-1:0] INIT     = '0
)
(
   input  wire logic         clk_in,  // System clock
   input  wire logic         rst_in,  // Synchronous reset
   input  wire logic [W-1:0] d_in,    // Asynchronous pins
   output logic      [W-1:0] q_out    // Synchronised pins
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge clk_in)
         begin
            if (rst_in)
            begin
               meta_ff[i] <= INIT[i];
               q_ff[i]    <= INIT[i];
            end
            else
            begin
               meta_ff[i] <= d_in[i];
               q_ff[i]    <= meta_ff[i];
            end
         end
      end
   endgenerate

   assign q_out = q_ff;
endmodule

// file: dma_chan1_model.sv
`timescale 1ns/1ps
module dma_chan1_model
(
   input  wire logic clk_in,          // System clock
   input  wire logic rst_in,          // Sync reset, high
   input  wire logic line_n_in,       // Channel 1 control line
   input  wire logic irq_enable_in,   // Channel irq enable
   input  wire logic clear_in,        // Software clears the flags
   input  wire logic chain_end_in,    // Last byte of the last block moved
   output logic      transition_out,  // Line transition flag
   output logic      op_complete_out, // Operation complete flag
   output logic      irq_request_n_out // Interrupt request, low
);
   logic [2:0] hist_ff;
   logic       flag_ff;
   logic       done_ff;
   // A fall counts only once it has stayed low for two cycles
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         hist_ff <= 3'h7;
         flag_ff <= 1'b0;
         done_ff <= 1'b0;
      end
      else
      begin
         hist_ff <= {hist_ff[1:0], line_n_in};
         if (clear_in)
            flag_ff <= 1'b0;
         else if (hist_ff == 3'h4)
            flag_ff <= 1'b1;
         // Completion only counts at the end of the whole chain
         if (clear_in)
            done_ff <= 1'b0;
         else if (chain_end_in)
            done_ff <= 1'b1;
      end
   end
   assign transition_out = flag_ff;
   assign op_complete_out = done_ff;
   assign irq_request_n_out = ~(irq_enable_in & (flag_ff | done_ff));
endmodule

// file: test_sync_irq_combiner.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module test_sync_irq_combiner;
   import sync_irq_pkg::*;
   logic        clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [3:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, line_n, xreq, gdly, flag, irq_n;
   logic        dav_n = 1, tl_irq = 0, berr_n = 1, own_n = 1, done_n = 1, g0_n = 1;
   logic        g1_n = 1, carry = 0, tl_req = 1, gin = 0, irq_en = 0, clr = 0;
   logic        chain_end = 0, op_done;
   int          errors = 0, check_count = 0;
   always #50 clk_in = ~clk_in;
   sync_irq_combiner sync_irq_combiner_i (.clk_in(clk_in), .rst_in(rst_in), .paddr_in(paddr),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .dav_n_in(dav_n),
      .tl_irq_in(tl_irq), .bus_exc_code1_n_in(berr_n), .dma_own_n_in(own_n),
      .done_n_in(done_n), .chan0_grant_n_in(g0_n), .chan1_grant_n_in(g1_n),
      .carry_sent_in(carry), .tl_xfer_req_in(tl_req), .grant_in_seen_in(gin),
      .periph_control_line_n_out(line_n), .xfer_request_line_out(xreq),
      .grant_seen_dly_out(gdly));
   dma_chan1_model dma_chan1_model_i (.clk_in(clk_in), .rst_in(rst_in), .line_n_in(line_n),
      .irq_enable_in(irq_en), .clear_in(clr), .chain_end_in(chain_end),
      .transition_out(flag), .op_complete_out(op_done), .irq_request_n_out(irq_n));
   task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16)
         errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_line(input logic v, input string nm);
      int n;
      n = 0;
      while (line_n !== v && n < 12)
      begin
         @(posedge clk_in);
         n++;
      end
      `CHK(nm, v, line_n)
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk_in);
      errors++;
      wrap_up();
   end
   initial
   begin
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      `CHK("idle line", 1'b1, line_n)
      xfer(STATUS_OFFSET, 1'b0, 32'h0000_0000);
      `CHK("status", (32'(1) << ST_DAV_BIT) | (32'(1) << ST_PCL_BIT), rd)
      xfer(4'h8, 1'b0, 32'h0000_0000);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0000_0000, rd)
      $display("test reset done");
      irq_en <= 1'b1;
      tl_irq <= 1'b1;
      wait_line(1'b0, "ctl irq");
      repeat (3) @(posedge clk_in);
      `CHK("flag", 1'b1, flag)
      `CHK("irq req", 1'b0, irq_n)
      tl_irq <= 1'b0;
      clr <= 1'b1;
      wait_line(1'b1, "ctl release");
      clr <= 1'b0;
      $display("test ctl irq done");
      berr_n <= 1'b0;
      repeat (6) @(posedge clk_in);
      `CHK("berr not master", 1'b1, line_n)
      own_n <= 1'b0;
      wait_line(1'b0, "berr master");
      berr_n <= 1'b1;
      own_n <= 1'b1;
      wait_line(1'b1, "berr gone");
      $display("test bus error done");
      xfer(CFG_OFFSET, 1'b1, 32'h0000_0000);
      dav_n <= 1'b0;
      done_n <= 1'b0;
      repeat (4) @(posedge clk_in);
      done_n <= 1'b1;
      xfer(STATUS_OFFSET, 1'b0, 32'h0000_0000);
      `CHK("no arm", 1'b0, rd[ST_ARMED_BIT])
      done_n <= 1'b0;
      g0_n <= 1'b0;
      repeat (4) @(posedge clk_in);
      done_n <= 1'b1;
      g0_n <= 1'b1;
      xfer(STATUS_OFFSET, 1'b0, 32'h0000_0000);
      `CHK("armed", 1'b1, rd[ST_ARMED_BIT])
      `CHK("req masked", 1'b0, xreq)
      `CHK("dav low", 1'b1, line_n)
      dav_n <= 1'b1;
      wait_line(1'b0, "dav rise");
      xfer(CFG_OFFSET, 1'b1, 32'h0000_0000);
      wait_line(1'b1, "cfg clear");
      `CHK("req free", 1'b1, xreq)
      $display("test dir0 done");
      clr <= 1'b1;
      xfer(CFG_OFFSET, 1'b1, 32'h0000_0003);
      clr <= 1'b0;
      carry <= 1'b1;
      g1_n <= 1'b0;
      repeat (4) @(posedge clk_in);
      g1_n <= 1'b1;
      wait_line(1'b0, "dav level");
      repeat (3) @(posedge clk_in);
      `CHK("carry flag", 1'b1, flag)
      `CHK("no complete", 1'b0, op_done)
      xfer(CFG_OFFSET, 1'b1, 32'h0000_0003);
      wait_line(1'b1, "cfg clear2");
      carry <= 1'b0;
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      chain_end <= 1'b1;
      @(posedge clk_in);
      chain_end <= 1'b0;
      @(posedge clk_in);
      `CHK("complete irq", 1'b0, irq_n)
      `CHK("flag cleared", 1'b0, flag)
      $display("test dir1 carry done");
      gin <= 1'b1;
      @(posedge clk_in);
      @(posedge clk_in);
      `CHK("grant held", 1'b0, gdly)
      @(posedge clk_in);
      `CHK("grant hold off", 1'b0, gdly)
      @(posedge clk_in);
      `CHK("grant seen", 1'b1, gdly)
      $display("test grant done");
      wrap_up();
   end
endmodule
